/* File: verilog/rolc_top.v */
// How it works
// - Protection code is four BCD digits, readable before it is rewritten.
// - A clear key zeroes the pending code before new digits enter.
// - Keying the code in run mode toggles lock, briefly flagging on or off.
// - Security timeout counts whole seconds without input signal before securing.
// - A stored timeout of zero disables the security function.
// - Only the last four digit keys are compared against the code.
// - Current output follows either the rate or the batch total.
// - High setpoint not above low gives a warning and reopens low entry.
// - Analog setup stays open until a valid setpoint pair is stored.
// - Source below low setpoint holds the current at its lower limit.
// - Source above high setpoint holds the current at its upper limit.
// - Current command recomputes whenever the displayed value changes.
// - One output pulse per increment of the scaled batch counter.
// - Pulse rate is one of four settings, stepped cyclically by each write with bit 1 set.
// - Excess pulses wait in a backlog of up to 9999.
// - An increment arriving at a full backlog raises the data-lost warning flag.
// - Base rate per second is taken as written to the rate input register.
// - Rate unit selects seconds, minutes times 60 or hours times 3600.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`include "rolc_consts.vh"
`default_nettype none
module rolc_top #(
    parameter SEC_CYCLES = `ROLC_SEC_CYCLES,
    parameter MSG_CYCLES = `ROLC_MSG_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        signal_in,
    input  wire        count_tick,
    output reg         pulse_out,
    output reg  [15:0] current_cmd,
    output reg         locked,
    output reg         backlog_overflow_warning
);

////////////////////////////////////////////////////////////////////////////////
// Register storage and bus handshake.

reg  [15:0] lock_code;
reg  [7:0]  security_timeout_prompt_secs;
reg         current_follows_batch_total;
reg  [31:0] alg_low;
reg  [31:0] alg_high;
reg         alg_valid;
reg         high_le_low;
reg  [1:0]  pulse_sel;
reg  [1:0]  rate_unit;
reg  [31:0] rate_in;
reg  [31:0] total_in;
reg  [15:0] recent_digits;
reg         secured;
reg         lock_msg;
reg         unlock_msg;
reg  [31:0] msg_cnt;
reg  [31:0] sec_cnt;
reg  [7:0]  idle_secs;
reg  [13:0] backlog;
reg  [31:0] emit_cnt;
reg  [1:0]  sig_sync;
reg  [1:0]  tick_sync;
reg         tick_prev;
reg  [7:0]  aw_addr;
reg         aw_have;
reg  [31:0] w_data;
reg         w_have;
reg  [31:0] rate_scaled;

wire        wr_go  = aw_have && w_have && !s_axi_bvalid;
wire        key_wr = wr_go && (aw_addr == `ROLC_OFF_KEY);
wire [3:0]  key    = w_data[3:0];
wire        key_digit = w_data[4];
wire        key_clear = w_data[5];
wire [31:0] status = {25'h0000000, alg_valid, unlock_msg, lock_msg, high_le_low,
                      backlog_overflow_warning, secured, locked};

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        aw_have       <= 1'b0;
        w_have        <= 1'b0;
        aw_addr       <= 8'h00;
        w_data        <= 32'h00000000;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= 2'h0;
    end else begin
        s_axi_awready <= !aw_have && !s_axi_awready;
        s_axi_wready  <= !w_have && !s_axi_wready;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            s_axi_wready <= 1'b0;
        end
        if (wr_go) begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[1:0] == 2'h0 && aw_addr <= `ROLC_OFF_TOTAL_IN)
                            ? 2'h0 : 2'h2;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration writes, code entry and lock toggling.

always @(posedge aclk) begin
    if (!aresetn) begin
        lock_code  <= `ROLC_CODE_RESET;
        security_timeout_prompt_secs <= `ROLC_SECURITY_TIMEOUT_PROMPT_RESET;
        current_follows_batch_total <= 1'b0;
        alg_low    <= 32'h00000000;
        alg_high   <= 32'h00000001;
        alg_valid  <= 1'b1;
        high_le_low <= 1'b0;
        pulse_sel  <= 2'h0;
        rate_unit  <= 2'h0;
        rate_in    <= 32'h00000000;
        total_in   <= 32'h00000000;
        recent_digits <= 16'h0000;
        locked     <= 1'b0;
        lock_msg   <= 1'b0;
        unlock_msg <= 1'b0;
        msg_cnt    <= 32'h00000000;
    end else begin
        if (msg_cnt != 32'h00000000) begin
            msg_cnt <= msg_cnt - 32'h00000001;
        end else begin
            lock_msg   <= 1'b0;
            unlock_msg <= 1'b0;
        end
        if (wr_go && !locked && !secured) begin
            case (aw_addr)
                `ROLC_OFF_CODE: begin
                    lock_code <= key_clear ? 16'h0000 : w_data[15:0];
                end
                `ROLC_OFF_SECURITY_TIMEOUT_PROMPT: begin
                    security_timeout_prompt_secs <= w_data[7:0];
                end
                `ROLC_OFF_ALG_SRC: begin
                    current_follows_batch_total <= w_data[0];
                end
                `ROLC_OFF_ALG_LOW: begin
                    alg_low   <= w_data;
                    alg_valid <= 1'b0;
                    high_le_low <= 1'b0;
                end
                `ROLC_OFF_ALG_HIGH: begin
                    if ($signed(w_data) <= $signed(alg_low)) begin
                        high_le_low <= 1'b1;
                        alg_valid   <= 1'b0;
                    end else begin
                        alg_high    <= w_data;
                        high_le_low <= 1'b0;
                        alg_valid   <= 1'b1;
                    end
                end
                `ROLC_OFF_PULSE_SEL: begin
                    if (w_data[1]) begin
                        pulse_sel <= pulse_sel + 2'h1;
                    end else begin
                        pulse_sel <= w_data[1] ? pulse_sel : pulse_sel;
                    end
                end
                `ROLC_OFF_RATE_UNIT: begin
                    rate_unit <= w_data[1:0];
                end
                default: begin
                end
            endcase
        end
        if (wr_go && aw_addr == `ROLC_OFF_RATE_IN) begin
            rate_in <= w_data;
        end
        if (wr_go && aw_addr == `ROLC_OFF_TOTAL_IN) begin
            total_in <= w_data;
        end
        if (key_wr && key_digit && key <= 4'h9) begin
            recent_digits <= {recent_digits[11:0], key};
            if ({recent_digits[11:0], key} == lock_code) begin
                locked     <= !locked;
                lock_msg   <= !locked;
                unlock_msg <= locked;
                msg_cnt    <= MSG_CYCLES;
            end
        end
        if (secured && !locked) begin
            locked <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Security timeout on missing input signal.

always @(posedge aclk) begin
    if (!aresetn) begin
        sig_sync  <= 2'h0;
        tick_sync <= 2'h0;
        tick_prev <= 1'b0;
        sec_cnt   <= 32'h00000000;
        idle_secs <= 8'h00;
        secured   <= 1'b0;
    end else begin
        sig_sync  <= {sig_sync[0], signal_in};
        tick_sync <= {tick_sync[0], count_tick};
        tick_prev <= tick_sync[1];
        if (locked && key_wr && key_digit && secured) begin
            secured <= 1'b0;
        end
        if (security_timeout_prompt_secs == 8'h00 || sig_sync[1]) begin
            sec_cnt   <= 32'h00000000;
            idle_secs <= 8'h00;
        end else if (sec_cnt >= SEC_CYCLES - 1) begin
            sec_cnt   <= 32'h00000000;
            idle_secs <= idle_secs + 8'h01;
            if (idle_secs + 8'h01 >= security_timeout_prompt_secs) begin
                secured <= 1'b1;
            end
        end else begin
            sec_cnt <= sec_cnt + 32'h00000001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pulse output with backlog.

reg [31:0] emit_period;
always @* begin
    case (pulse_sel)
        2'h0:    emit_period = 32'd6250;
        2'h1:    emit_period = 32'd62500;
        2'h2:    emit_period = 32'd625000;
        default: emit_period = 32'd12500000;
    endcase
end

wire count_edge = tick_sync[1] && !tick_prev;
wire emit_now   = (emit_cnt == 32'h00000000) && (backlog != 14'd0);

always @(posedge aclk) begin
    if (!aresetn) begin
        backlog   <= 14'd0;
        emit_cnt  <= 32'h00000000;
        pulse_out <= 1'b0;
        backlog_overflow_warning <= 1'b0;
    end else begin
        pulse_out <= emit_now;
        if (emit_cnt != 32'h00000000) begin
            emit_cnt <= emit_cnt - 32'h00000001;
        end else if (emit_now) begin
            emit_cnt <= emit_period - 32'h00000001;
        end
        if (count_edge && !emit_now) begin
            if (backlog < `ROLC_BACKLOG_MAX) begin
                backlog <= backlog + 14'd1;
            end
        end else if (!count_edge && emit_now) begin
            backlog <= backlog - 14'd1;
        end
        if (count_edge && backlog == `ROLC_BACKLOG_MAX) begin
            backlog_overflow_warning <= 1'b1;
        end else if (wr_go && aw_addr == `ROLC_OFF_STATUS && w_data[2]) begin
            backlog_overflow_warning <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Rate scaling and current output.

wire [31:0] src  = current_follows_batch_total ? total_in : rate_scaled;
wire [63:0] span = {32'h00000000, src - alg_low} * 64'd16000;
wire [63:0] den  = {32'h00000000, alg_high - alg_low};
wire [63:0] quot = span / den;

always @(posedge aclk) begin
    if (!aresetn) begin
        rate_scaled <= 32'h00000000;
        current_cmd <= `ROLC_CUR_MIN;
    end else begin
        case (rate_unit)
            2'h1:    rate_scaled <= rate_in * 32'd60;
            2'h2:    rate_scaled <= rate_in * 32'd3600;
            default: rate_scaled <= rate_in;
        endcase
        if ($signed(src) <= $signed(alg_low)) begin
            current_cmd <= `ROLC_CUR_MIN;
        end else if ($signed(src) >= $signed(alg_high)) begin
            current_cmd <= `ROLC_CUR_MAX;
        end else begin
            current_cmd <= `ROLC_CUR_MIN + quot[15:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register reads.

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= 2'h0;
    end else begin
        s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr)
                `ROLC_OFF_CODE:      s_axi_rdata <= {16'h0000, lock_code};
                `ROLC_OFF_SECURITY_TIMEOUT_PROMPT:     s_axi_rdata <= {24'h000000, security_timeout_prompt_secs};
                `ROLC_OFF_ALG_SRC:   s_axi_rdata <= {31'h00000000, current_follows_batch_total};
                `ROLC_OFF_ALG_LOW:   s_axi_rdata <= alg_low;
                `ROLC_OFF_ALG_HIGH:  s_axi_rdata <= alg_high;
                `ROLC_OFF_PULSE_SEL: s_axi_rdata <= {30'h00000000, pulse_sel};
                `ROLC_OFF_RATE_UNIT: s_axi_rdata <= {30'h00000000, rate_unit};
                `ROLC_OFF_STATUS:    s_axi_rdata <= status;
                `ROLC_OFF_RATE_IN:   s_axi_rdata <= rate_in;
                `ROLC_OFF_TOTAL_IN:  s_axi_rdata <= total_in;
                `ROLC_OFF_CURRENT:   s_axi_rdata <= {16'h0000, current_cmd};
                `ROLC_OFF_BACKLOG:   s_axi_rdata <= {18'h00000, backlog};
                `ROLC_OFF_RATE_OUT:  s_axi_rdata <= rate_scaled;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

/* File: common/rolc_consts.vh */
`ifndef ROLC_CONSTS_VH
`define ROLC_CONSTS_VH
`define ROLC_OFF_CODE        8'h00
`define ROLC_OFF_SECURITY_TIMEOUT_PROMPT       8'h04
`define ROLC_OFF_ALG_SRC     8'h08
`define ROLC_OFF_ALG_LOW     8'h0C
`define ROLC_OFF_ALG_HIGH    8'h10
`define ROLC_OFF_PULSE_SEL   8'h14
`define ROLC_OFF_RATE_UNIT   8'h18
`define ROLC_OFF_KEY         8'h1C
`define ROLC_OFF_STATUS      8'h20
`define ROLC_OFF_RATE_IN     8'h24
`define ROLC_OFF_TOTAL_IN    8'h28
`define ROLC_OFF_CURRENT     8'h2C
`define ROLC_OFF_BACKLOG     8'h30
`define ROLC_OFF_RATE_OUT    8'h34
`define ROLC_CODE_RESET      16'h1000
`define ROLC_SECURITY_TIMEOUT_PROMPT_RESET     8'h00
`define ROLC_BACKLOG_MAX     14'd9999
`define ROLC_CUR_MIN         16'h0FA0
`define ROLC_CUR_MAX         16'h4E20
`define ROLC_CLK_HZ          125000000
`define ROLC_SEC_CYCLES      (`ROLC_CLK_HZ / 1)
`define ROLC_MSG_CYCLES      (`ROLC_CLK_HZ / 2)
`define ROLC_ST_LOCKED       0
`define ROLC_ST_SECURE       1
`define ROLC_ST_OVERFLOW     2
`define ROLC_ST_HIGH_LE_LOW  3
`define ROLC_ST_LOCK_MSG     4
`define ROLC_ST_UNLOCK_MSG   5
`define ROLC_ST_ALG_VALID    6
`endif

/* File: test/rolc_top_sva.sv */
`default_nettype none
module rolc_top_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        pulse_out,
    input wire logic [15:0] current_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [12:0] gap;
    // Cycles since the last output pulse, saturating.
    always @(posedge aclk) begin
        if (!aresetn) begin
            gap <= 13'h1FFF;
        end else if (pulse_out) begin
            gap <= 13'h0;
        end else if (gap != 13'h1FFF) begin
            gap <= gap + 13'h1;
        end
    end
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_cur_range;
        current_cmd >= 16'h0FA0 && current_cmd <= 16'h4E20;
    endproperty
    property p_pulse_one;
        pulse_out |=> !pulse_out;
    endproperty
    property p_pulse_gap;
        pulse_out |-> gap >= 13'h1869;
    endproperty
    property p_wr_ans;
        s_wr |-> ##2 s_axi_bvalid;
    endproperty
    property p_rd_ans;
        s_rd |=> s_axi_rvalid;
    endproperty
    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    property p_bresp;
        s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2;
    endproperty
    a_cur_range: assert property (p_cur_range)
        else $error("current command out of range");
    a_pulse_one: assert property (p_pulse_one)
        else $error("pulse wider than one cycle");
    a_pulse_gap: assert property (p_pulse_gap)
        else $error("pulses closer than fastest rate");
    a_wr_ans: assert property (p_wr_ans)
        else $error("write response late");
    a_rd_ans: assert property (p_rd_ans)
        else $error("read data late");
    a_b_once: assert property (p_b_once)
        else $error("write response repeated");
    a_r_once: assert property (p_r_once)
        else $error("read data repeated");
    a_bresp: assert property (p_bresp)
        else $error("illegal write response");
endmodule
bind rolc_top rolc_top_sva rolc_top_sva_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pulse_out, .current_cmd);
`default_nettype wire

/* File: test/rolc_field.sv */
`default_nettype none
module rolc_field (
    input  wire logic aclk,
    input  wire logic pulse_out,
    output var logic  count_tick,
    output var logic  signal_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int pulses = 0;
    initial begin
        count_tick = 1'b0;
        signal_in = 1'b0;
    end
    // Counts emitted pulses.
    always @(posedge aclk) begin
        if (pulse_out) begin
            pulses <= pulses + 1;
        end
    end
    // Each increment is two cycles high and two low, so the synchroniser sees it.
    task automatic send(input int n);
        repeat (n) begin
            @(posedge aclk);
            count_tick <= 1'b1;
            repeat (2) @(posedge aclk);
            count_tick <= 1'b0;
            @(posedge aclk);
        end
    endtask
    // Sets the input activity level after the next clock edge.
    task automatic activity(input logic v);
        @(posedge aclk);
        signal_in <= v;
    endtask
endmodule
`default_nettype wire

/* File: test/rolc_top_test.sv */
`default_nettype none
module rolc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, signal_in, count_tick, pulse_out, locked, backlog_overflow_warning;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp_seen;
    logic [15:0] current_cmd;
    logic [31:0] rate_exp [3] = '{32'h5, 32'h12C, 32'h4650};
    int          bad_count = 0;
    int          checks_done = 0;
    rolc_top #(.SEC_CYCLES(10), .MSG_CYCLES(40)) rolc_top_inst (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .signal_in, .count_tick,
        .pulse_out, .current_cmd, .locked, .backlog_overflow_warning);
    rolc_field rolc_field_inst (.aclk, .pulse_out, .count_tick, .signal_in);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 99; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        resp_seen = s_axi_bresp;
        if (n == 99) begin
            bad_count++;
            complete_run;
        end
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 99; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        rd_data = s_axi_rdata;
        resp_seen = s_axi_rresp;
        if (n == 99) begin
            bad_count++;
            complete_run;
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk($sformatf("register %h", a), e, rd_data & m);
    endtask
    task automatic key(input logic [3:0] d);
        wr(8'h1C, {27'h0, 1'b1, d});
    endtask
    task automatic code(input logic [15:0] c);
        key(c[15:12]);
        key(c[11:8]);
        key(c[7:4]);
        key(c[3:0]);
    endtask
    task automatic cur(input logic [15:0] e);
        rc(8'h2C, 32'hFFFF, {16'h0, e});
        chk("current_cmd", {16'h0, e}, {16'h0, current_cmd});
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        int n;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rc(8'h00, 32'hFFFF, 32'h1000);
        cur(16'h0FA0);
        key(4'h9);
        code(16'h1000);
        rc(8'h20, 32'h11, 32'h11);
        chk("locked", 32'h1, {31'h0, locked});
        wr(8'h00, 32'h20);
        rc(8'h00, 32'hFFFF, 32'h1000);
        repeat (50) @(posedge aclk);
        rc(8'h20, 32'h10, 32'h0);
        code(16'h1000);
        rc(8'h20, 32'h21, 32'h20);
        wr(8'h00, 32'h20);
        rc(8'h00, 32'hFFFF, 32'h0);
        wr(8'h00, 32'h7509);
        rc(8'h00, 32'hFFFF, 32'h7509);
        code(16'h7509);
        rc(8'h20, 32'h1, 32'h1);
        code(16'h7509);
        rc(8'h20, 32'h1, 32'h0);
        rd(8'h40);
        chk("read response", 32'h2, {30'h0, resp_seen});
        wr(8'h40, 32'h1);
        chk("write response", 32'h2, {30'h0, resp_seen});
        wr(8'h0C, 32'h64);
        wr(8'h10, 32'h32);
        rc(8'h20, 32'h48, 32'h08);
        wr(8'h10, 32'h12C);
        rc(8'h20, 32'h48, 32'h40);
        wr(8'h24, 32'h32);
        cur(16'h0FA0);
        wr(8'h24, 32'hC8);
        cur(16'h2EE0);
        wr(8'h24, 32'h190);
        cur(16'h4E20);
        wr(8'h28, 32'h96);
        wr(8'h08, 32'h1);
        cur(16'h1F40);
        wr(8'h24, 32'h5);
        for (i = 0; i < 3; i++) begin
            wr(8'h18, 32'(i));
            rc(8'h34, 32'hFFFFFFFF, rate_exp[i]);
        end
        for (i = 1; i < 5; i++) begin
            wr(8'h14, 32'h2);
            rc(8'h14, 32'h3, 32'(i % 4));
        end
        rolc_field_inst.send(3);
        for (n = 0; n < 30000 && rolc_field_inst.pulses < 3; n++) @(posedge aclk);
        chk("pulse count", 32'h3, rolc_field_inst.pulses);
        rc(8'h30, 32'h3FFF, 32'h0);
        repeat (3) wr(8'h14, 32'h2);
        rolc_field_inst.send(10002);
        rc(8'h30, 32'h3FFF, 32'h270F);
        rc(8'h20, 32'h4, 32'h4);
        chk("warning", 32'h1, {31'h0, backlog_overflow_warning});
        wr(8'h20, 32'h4);
        rc(8'h20, 32'h4, 32'h0);
        repeat (30) @(posedge aclk);
        rc(8'h20, 32'h2, 32'h0);
        rolc_field_inst.activity(1'b1);
        wr(8'h04, 32'h2);
        repeat (30) @(posedge aclk);
        rc(8'h20, 32'h2, 32'h0);
        rolc_field_inst.activity(1'b0);
        repeat (25) @(posedge aclk);
        rc(8'h20, 32'h2, 32'h2);
        complete_run;
    end
endmodule
`default_nettype wire
